// ==== hw/fsk_consts.vh ====
// constants for the flash security and key unlock block
`ifndef FSK_CONSTS_VH
`define FSK_CONSTS_VH

// ==========================================================================
// register indices (byte address on the bus is four times the index)
`define FSK_IDX_OPTION_WORK   16'h1821
`define FSK_IDX_FLASH_CONFIG  16'h1823
`define FSK_IDX_PROT_WORK     16'h1824
`define FSK_IDX_KEY_FIRST     16'hffb0
`define FSK_IDX_KEY_LAST      16'hffb7
`define FSK_IDX_NV_PROT       16'hffbd
`define FSK_IDX_NV_OPT        16'hffbf
`define FSK_IDX_SEC_STATUS    16'h1827

// ==========================================================================
// field positions
`define FSK_BIT_KEY_ENABLE    7
`define FSK_BIT_KEY_ACCESS    5
`define FSK_SEC_HI            1
`define FSK_SEC_LO            0
`define FSK_SEC_UNSECURED     2'h2
`define FSK_CONFIG_MASK       8'h20
`define FSK_OPT_MASK          8'hc3

// ==========================================================================
// bus answers and widths
`define FSK_ADDR_W            18
`define FSK_KEY_BYTES         8
`define FSK_RESP_OKAY         2'h0
`define FSK_RESP_SLVERR       2'h2
`define FSK_RESP_DECERR       2'h3
`define FSK_BYTE_RESET        8'h00

`endif

// ==== hw/fsk_byte_match.v ====
// one byte comparator of the backdoor key check
`timescale 1ns/10ps
`default_nettype none

module fsk_byte_match
#(
   parameter W = 8
)
(
   // operands
   input  wire [W-1:0] presented,
   input  wire [W-1:0] stored,
   // result
   output wire         equal
);

   // equality of one key byte
   assign equal = (presented == stored);

endmodule // fsk_byte_match

`default_nettype wire

// ==== hw/fsk_flash_security.v ====
// flash security option logic with backdoor key unlock and an AXI4-Lite slave
`include "fsk_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module fsk_flash_security
#(
   parameter KEY_BYTES = `FSK_KEY_BYTES
)
(
   // clock, reset, enable
   input  wire                     clk,
   input  wire                     reset_n,
   input  wire                     clkEn,
   // nonvolatile contents from the flash array
   input  wire [8*KEY_BYTES-1:0]   nvKey,
   input  wire [7:0]               nv_protection_byte,
   input  wire [7:0]               nv_option_byte,
   // flash sequencer events and access origin
   input  wire                     massEraseDone,
   input  wire                     blankVerified,
   input  wire                     debugAccess,
   // write address channel
   input  wire                     s_axi_awvalid,
   output reg                      s_axi_awready,
   input  wire [`FSK_ADDR_W-1:0]   s_axi_awaddr,
   input  wire [2:0]               s_axi_awprot,
   // write data channel
   input  wire                     s_axi_wvalid,
   output reg                      s_axi_wready,
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   // write response channel
   output reg                      s_axi_bvalid,
   input  wire                     s_axi_bready,
   output reg  [1:0]               s_axi_bresp,
   // read address channel
   input  wire                     s_axi_arvalid,
   output reg                      s_axi_arready,
   input  wire [`FSK_ADDR_W-1:0]   s_axi_araddr,
   input  wire [2:0]               s_axi_arprot,
   // read data channel
   output reg                      s_axi_rvalid,
   input  wire                     s_axi_rready,
   output reg  [31:0]              s_axi_rdata,
   output reg  [1:0]               s_axi_rresp,
   // security and protection state
   output reg                      memSecure_r,
   output reg  [7:0]               protSetting_r
);

   // ========================================================================
   // state
   reg  [7:0]               optWork_r;        // option working register
   reg  [7:0]               protWork_r;       // protection working register
   reg  [7:0]               flashCfg_r;       // flash config, key access select
   reg                      keyUnlocked_r;    // key match seen since reset
   reg                      erased_r;         // mass erase done since reset
   reg                      eraseUnlocked_r;  // erase plus blank verify seen
   reg  [8*KEY_BYTES-1:0]   keyEntry_r;       // bytes presented so far
   reg  [KEY_BYTES-1:0]     keySeen_r;        // which bytes were presented
   reg                      keyCheck_r;       // all bytes in, compare now
   reg                      awHeld_r;
   reg                      wHeld_r;
   reg  [`FSK_ADDR_W-1:0]   awAddr_r;
   reg  [2:0]               awProt_r;
   reg  [31:0]              wData_r;
   reg  [3:0]               wStrb_r;

   wire [KEY_BYTES-1:0]     byteEq;
   wire                     keyMatch;
   wire [15:0]              wrIdx;
   wire [15:0]              rdIdx;
   wire                     keyEnabled;
   wire                     secFieldUnsec;
   wire                     unsecured;
   wire                     wrFire;
   wire [2:0]               keyOffset;
   wire                     wrIsKey;
   wire                     keyAllowed;

   reg  [1:0]               wrResp;
   reg  [31:0]              rdWord;
   reg  [1:0]               rdResp;

   // ========================================================================
   // key comparison, one comparator per byte
   genvar gi;
   generate
      for (gi = 0; gi < KEY_BYTES; gi = gi + 1)
      begin : gKeyByte
         fsk_byte_match #(.W(8)) uMatch
         (
            .presented (keyEntry_r[8*gi+7:8*gi]),
            .stored    (nvKey[8*gi+7:8*gi]),
            .equal     (byteEq[gi])
         );
      end
   endgenerate

   // every byte must agree
   assign keyMatch = &byteEq;

   // ========================================================================
   // decode and security state
   assign wrIdx         = awAddr_r[17:2];
   assign rdIdx         = s_axi_araddr[17:2];
   assign keyEnabled    = optWork_r[`FSK_BIT_KEY_ENABLE];
   assign secFieldUnsec = (optWork_r[`FSK_SEC_HI:`FSK_SEC_LO] == `FSK_SEC_UNSECURED);
   assign unsecured     = secFieldUnsec | keyUnlocked_r | eraseUnlocked_r;
   assign wrFire        = awHeld_r & wHeld_r & ~s_axi_bvalid;
   assign wrIsKey       = (wrIdx >= `FSK_IDX_KEY_FIRST) && (wrIdx <= `FSK_IDX_KEY_LAST);
   assign keyOffset     = wrIdx[2:0];
   // key path: enabled, selected, from secure code and never from debug
   assign keyAllowed    = keyEnabled
                          & flashCfg_r[`FSK_BIT_KEY_ACCESS]
                          & ~awProt_r[1]
                          & ~debugAccess;

   // ========================================================================
   // write response selection
   always @*
   begin
      wrResp = `FSK_RESP_OKAY;
      case (wrIdx)
         `FSK_IDX_OPTION_WORK,
         `FSK_IDX_FLASH_CONFIG,
         `FSK_IDX_PROT_WORK,
         `FSK_IDX_NV_PROT,
         `FSK_IDX_NV_OPT,
         `FSK_IDX_SEC_STATUS:
            wrResp = `FSK_RESP_OKAY;
         default:
         begin
            if (wrIsKey)
            begin
               if (!keyAllowed)
               begin
                  wrResp = `FSK_RESP_SLVERR;
               end
            end
            else
            begin
               wrResp = `FSK_RESP_DECERR;
            end
         end
      endcase
   end

   // ========================================================================
   // read data selection
   always @*
   begin
      rdWord = 32'h0000_0000;
      rdResp = `FSK_RESP_OKAY;
      case (rdIdx)
         `FSK_IDX_OPTION_WORK:
            rdWord = {24'h00_0000, optWork_r & `FSK_OPT_MASK};
         `FSK_IDX_FLASH_CONFIG:
            rdWord = {24'h00_0000, flashCfg_r};
         `FSK_IDX_PROT_WORK:
            rdWord = {24'h00_0000, protWork_r};
         `FSK_IDX_NV_PROT:
            rdWord = {24'h00_0000, nv_protection_byte};
         `FSK_IDX_NV_OPT:
            rdWord = {24'h00_0000, nv_option_byte};
         `FSK_IDX_SEC_STATUS:
            rdWord = {26'h000_0000, erased_r, eraseUnlocked_r, keyUnlocked_r,
                      keyEnabled, secFieldUnsec, ~unsecured};
         default:
         begin
            if ((rdIdx >= `FSK_IDX_KEY_FIRST) && (rdIdx <= `FSK_IDX_KEY_LAST))
            begin
               // key bytes stay hidden while the part is secured
               if (unsecured)
               begin
                  case (rdIdx[2:0])
                     3'h0:    rdWord = {24'h00_0000, nvKey[7:0]};
                     3'h1:    rdWord = {24'h00_0000, nvKey[15:8]};
                     3'h2:    rdWord = {24'h00_0000, nvKey[23:16]};
                     3'h3:    rdWord = {24'h00_0000, nvKey[31:24]};
                     3'h4:    rdWord = {24'h00_0000, nvKey[39:32]};
                     3'h5:    rdWord = {24'h00_0000, nvKey[47:40]};
                     3'h6:    rdWord = {24'h00_0000, nvKey[55:48]};
                     default: rdWord = {24'h00_0000, nvKey[63:56]};
                  endcase
               end
            end
            else
            begin
               rdResp = `FSK_RESP_DECERR;
            end
         end
      endcase
   end

   // ========================================================================
   // write address and data capture, in either order
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= {`FSK_ADDR_W{1'b0}};
         awProt_r      <= 3'h0;
         wData_r       <= 32'h0000_0000;
         wStrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FSK_RESP_OKAY;
      end
      else if (clkEn)
      begin
         s_axi_awready <= ~awHeld_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
            awProt_r <= s_axi_awprot;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrResp;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
         end
      end
   end

   // ========================================================================
   // read channel, one cycle answer
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `FSK_RESP_OKAY;
      end
      else if (clkEn)
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdWord;
            s_axi_rresp  <= rdResp;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ========================================================================
   // working registers, loaded from the nonvolatile bytes at every reset; flash config cleared to zero
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         optWork_r  <= nv_option_byte;
         protWork_r <= nv_protection_byte;
         flashCfg_r <= `FSK_BYTE_RESET;
      end
      else if (clkEn && wrFire && wStrb_r[0])
      begin
         if (wrIdx == `FSK_IDX_FLASH_CONFIG)
         begin
            flashCfg_r <= wData_r[7:0] & `FSK_CONFIG_MASK;
         end
         if (wrIdx == `FSK_IDX_PROT_WORK)
         begin
            protWork_r <= wData_r[7:0];
         end
      end
   end

   // ========================================================================
   // backdoor key entry and comparison
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         keyEntry_r    <= {8*KEY_BYTES{1'b0}};
         keySeen_r     <= {KEY_BYTES{1'b0}};
         keyCheck_r    <= 1'b0;
         keyUnlocked_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (keyCheck_r)
         begin
            // a complete attempt is judged once, then entry starts over
            if (keyMatch && keyEnabled)
            begin
               keyUnlocked_r <= 1'b1;
            end
            keySeen_r  <= {KEY_BYTES{1'b0}};
            keyCheck_r <= 1'b0;
         end
         else if (&keySeen_r)
         begin
            keyCheck_r <= 1'b1;
         end
         else if (wrFire && wrIsKey && keyAllowed && wStrb_r[0])
         begin
            case (keyOffset)
               3'h0:    keyEntry_r[7:0]   <= wData_r[7:0];
               3'h1:    keyEntry_r[15:8]  <= wData_r[7:0];
               3'h2:    keyEntry_r[23:16] <= wData_r[7:0];
               3'h3:    keyEntry_r[31:24] <= wData_r[7:0];
               3'h4:    keyEntry_r[39:32] <= wData_r[7:0];
               3'h5:    keyEntry_r[47:40] <= wData_r[7:0];
               3'h6:    keyEntry_r[55:48] <= wData_r[7:0];
               default: keyEntry_r[63:56] <= wData_r[7:0];
            endcase
            keySeen_r[keyOffset] <= 1'b1;
         end
      end
   end

   // ========================================================================
   // mass erase then blank verify releases security without the key
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         erased_r        <= 1'b0;
         eraseUnlocked_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (massEraseDone)
         begin
            erased_r <= 1'b1;
         end
         if (erased_r && blankVerified)
         begin
            eraseUnlocked_r <= 1'b1;
         end
      end
   end

   // ========================================================================
   // registered security and protection outputs
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         memSecure_r   <= 1'b1;
         protSetting_r <= `FSK_BYTE_RESET;
      end
      else if (clkEn)
      begin
         memSecure_r   <= ~unsecured;
         protSetting_r <= protWork_r;
      end
   end

endmodule // fsk_flash_security

`default_nettype wire

// ==== bench/fsk_flash_security_chk.sv ====
// assertion checker for the flash security block
`include "fsk_consts.vh"
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// checker
module fsk_flash_security_chk
#(
   parameter KEY_BYTES = 8
)
(
   // clock and reset
   input wire logic                   clk,
   input wire logic                   reset_n,
   // nonvolatile bytes and flash events
   input wire logic [7:0]             nv_protection_byte,
   input wire logic [7:0]             nv_option_byte,
   input wire logic                   massEraseDone,
   input wire logic                   debugAccess,
   // write channels
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic [`FSK_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0]             s_axi_awprot,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [1:0]             s_axi_bresp,
   // read channels
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic [31:0]            s_axi_rdata,
   // security state
   input wire logic                   memSecure_r,
   input wire logic [7:0]             protSetting_r
);
   logic [7:0] opt_r;
   logic       erased_r;
   logic       keyBad_r;

   // option byte seen at reset, erase seen since
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         opt_r    <= nv_option_byte;
         erased_r <= 1'b0;
      end
      else if (massEraseDone)
         erased_r <= 1'b1;
   end

   // key byte write that must be refused
   always @(posedge clk)
      if (s_axi_awvalid && s_axi_awready)
         keyBad_r <= (s_axi_awaddr[17:5] == 13'h1ff6) && (s_axi_awprot[1] || debugAccess || !opt_r[7]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_protLoad;
      $rose(reset_n) |-> ##[1:2] protSetting_r == nv_protection_byte;
   endproperty
   a_protLoad: assert property (p_protLoad) else $error("protection copy not loaded");
   property p_secField;
      $rose(reset_n) && nv_option_byte[1:0] == `FSK_SEC_UNSECURED |-> ##[1:2] !memSecure_r;
   endproperty
   a_secField: assert property (p_secField) else $error("unsecured field ignored");
   property p_keyOff;
      !opt_r[7] && opt_r[1:0] != `FSK_SEC_UNSECURED && !erased_r |-> memSecure_r;
   endproperty
   a_keyOff: assert property (p_keyOff) else $error("security lifted without key or erase");
   property p_refuse;
      s_axi_bvalid && keyBad_r |-> s_axi_bresp == `FSK_RESP_SLVERR;
   endproperty
   a_refuse: assert property (p_refuse) else $error("key write not refused");
   property p_bLat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_bLat: assert property (p_bLat) else $error("write response late");
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold) else $error("write response dropped");
   property p_rLat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rLat: assert property (p_rLat) else $error("read data late");
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rHold: assert property (p_rHold) else $error("read data dropped");
endmodule // fsk_flash_security_chk

bind fsk_flash_security fsk_flash_security_chk #(.KEY_BYTES(KEY_BYTES)) fsk_flash_security_chk_i
   (.clk, .reset_n, .nv_protection_byte, .nv_option_byte, .massEraseDone, .debugAccess, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .memSecure_r, .protSetting_r);
`default_nettype wire

// ==== bench/tb_fsk_flash_security.sv ====
// self-checking testbench for the flash security block
`include "fsk_consts.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

// ==========================================================
// bench
module tb_fsk_flash_security;
   logic        clk, reset_n, clkEn, massEraseDone, blankVerified, debugAccess;
   logic [63:0] nvKey;
   logic [7:0]  nv_protection_byte, nv_option_byte;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, r;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        memSecure_r;
   logic [7:0]  protSetting_r;
   logic [33:0] expQ[$];
   logic [33:0] expV;
   int          fails, checkCount;

   fsk_flash_security #(.KEY_BYTES(8)) fsk_flash_security_i (.clk, .reset_n, .clkEn, .nvKey,
      .nv_protection_byte, .nv_option_byte, .massEraseDone, .blankVerified, .debugAccess, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .memSecure_r, .protSetting_r);

   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // random source
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // compare each bus answer with the oldest note
   always @(posedge clk)
   begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      begin
         expV = expQ.pop_front();
         if (s_axi_bvalid)
            `CHK({s_axi_bresp, 32'h0}, expV)
         else
            `CHK({s_axi_rresp, s_axi_rdata}, expV)
      end
   end

   // one register write, both channels offered together
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [2:0] pr,
                     input logic [1:0] er);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      expQ.push_back({er, 32'h0});
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awprot  <= pr;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(a && w))
      begin
         @(posedge clk);
         if (s_axi_awready) a = 1'b1;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) w = 1'b1;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      repeat (rnd() % 3) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   // one register read, ready raised after a random stall
   task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      expQ.push_back({er, 24'h0, d});
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (rnd() % 3) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // eight key bytes, lowest index first
   task automatic key(input logic [63:0] k, input logic [1:0] er);
      for (int i = 0; i < 8; i++)
         wr(16'hffb0 + 16'(i), k[8*i+:8], 3'h0, er);
      repeat (4) @(posedge clk);
   endtask

   // reset with a given option byte and a random protection byte
   task automatic rst(input logic [7:0] opt);
      logic [31:0] v;
      v = rnd();
      nv_option_byte   <= opt;
      nv_protection_byte  <= v[7:0];
      reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   // pulse one flash event input
   task automatic pulse(input logic which);
      if (which) massEraseDone <= 1'b1;
      else blankVerified <= 1'b1;
      @(posedge clk);
      massEraseDone <= 1'b0;
      blankVerified <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // closing verdict
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end

   // main sequence
   initial
   begin
      {reset_n, massEraseDone, blankVerified, debugAccess, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_awprot, s_axi_arprot, nv_protection_byte, nv_option_byte, fails, checkCount} = '0;
      clkEn = 1'b1;
      s_axi_wstrb = 4'hf;
      seed = 32'hfcbb;
      nvKey = {rnd(), rnd()};
      rst(8'h81);
      `CHK(protSetting_r, nv_protection_byte)
      `CHK(memSecure_r, 1'b1)
      rd(16'h1821, 8'h81, `FSK_RESP_OKAY);
      rd(16'hffbd, nv_protection_byte, `FSK_RESP_OKAY);
      rd(16'hffb0, 8'h00, `FSK_RESP_OKAY);
      rd(16'h1822, 8'h00, `FSK_RESP_DECERR);
      wr(16'h1822, 8'h00, 3'h0, `FSK_RESP_DECERR);
      wr(16'h1821, 8'h00, 3'h0, `FSK_RESP_OKAY);
      rd(16'h1821, 8'h81, `FSK_RESP_OKAY);
      r = rnd();
      wr(16'h1824, r[7:0], 3'h0, `FSK_RESP_OKAY);
      rd(16'h1824, r[7:0], `FSK_RESP_OKAY);
      `CHK(protSetting_r, r[7:0])
      $display("test registers done");
      wr(16'hffb0, nvKey[7:0], 3'h0, `FSK_RESP_SLVERR);
      wr(16'h1823, 8'h20, 3'h0, `FSK_RESP_OKAY);
      wr(16'hffb3, nvKey[31:24], 3'h2, `FSK_RESP_SLVERR);
      debugAccess <= 1'b1;
      wr(16'hffb0, nvKey[7:0], 3'h0, `FSK_RESP_SLVERR);
      debugAccess <= 1'b0;
      key(nvKey ^ (64'h1 << (8 * (r % 8))), `FSK_RESP_OKAY);
      `CHK(memSecure_r, 1'b1)
      key(nvKey, `FSK_RESP_OKAY);
      `CHK(memSecure_r, 1'b0)
      rd(16'hffb7, nvKey[63:56], `FSK_RESP_OKAY);
      rd(16'h1827, 8'h0c, `FSK_RESP_OKAY);
      rst(8'h81);
      `CHK(memSecure_r, 1'b1)
      $display("test key unlock done");
      rst(8'h01);
      wr(16'h1823, 8'h20, 3'h0, `FSK_RESP_OKAY);
      key(nvKey, `FSK_RESP_SLVERR);
      `CHK(memSecure_r, 1'b1)
      pulse(1'b0);
      `CHK(memSecure_r, 1'b1)
      pulse(1'b1);
      `CHK(memSecure_r, 1'b1)
      pulse(1'b0);
      `CHK(memSecure_r, 1'b0)
      rd(16'h1827, 8'h30, `FSK_RESP_OKAY);
      $display("test key disabled done");
      for (int v = 0; v < 4; v++)
      begin
         rst(8'(v));
         `CHK(memSecure_r, (v != 2))
      end
      $display("test security field done");
      @(posedge clk);
      summarize();
   end
endmodule // tb_fsk_flash_security
`default_nettype wire
